// [hdl/jump_inc_pkg.sv]
// Shared opcodes, addressing modes, flag layout and reset values
package jump_inc_pkg;

    // Upper opcode patterns
    localparam logic [7:0] OPC_JUMP_ABS = 8'hEC ^ 8'hE8;
    localparam logic [19:0] OPC_JUMP_IND = 20'h0_1400;
    localparam logic [7:0] OPC_INC_FILE = 8'hEC;
    localparam logic [7:0] OPC_INC_REG = 8'hE8;

    // Field positions inside the increment opcodes
    localparam int BIT_BY_TWO = 15;
    localparam int BIT_BYTE = 14;
    localparam int BIT_DEST_SEL = 13;

    // Addressing modes of the register forms
    localparam logic [2:0] MODE_DIRECT = 3'h0;
    localparam logic [2:0] MODE_IND = 3'h1;
    localparam logic [2:0] MODE_POST_DEC = 3'h2;
    localparam logic [2:0] MODE_POST_INC = 3'h3;
    localparam logic [2:0] MODE_PRE_DEC = 3'h4;
    localparam logic [2:0] MODE_PRE_INC = 3'h5;

    // Status flag positions
    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_OVERFLOW = 2;
    localparam int FLG_N = 3;
    localparam int FLG_DIGIT_CARRY = 4;

    localparam logic [4:0] STATUS_RESET = 5'h00;
    localparam logic [22:0] PC_RESET = 23'h00_0000;
    localparam logic [3:0] DEFAULT_WORK_REG_IDX = 4'h0;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_WORD2 = 5'h02,
        ST_FLUSH = 5'h04,
        ST_RDWAIT = 5'h08,
        ST_EXEC = 5'h10
    } state_t;

endpackage : jump_inc_pkg

// [hdl/work_reg_file.sv]
// Working register file with two read ports and one byte-lane write port
`timescale 1ns/10ps
`default_nettype none
module work_reg_file #(
    parameter int DATA_W = 16,
    parameter int DEPTH = 16,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic [AW-1:0] rd_a_idx_i,
    output logic [DATA_W-1:0] rd_a_data_o,
    input wire logic [AW-1:0] rd_b_idx_i,
    output logic [DATA_W-1:0] rd_b_data_o,
    input wire logic we_i,
    input wire logic [AW-1:0] wr_idx_i,
    input wire logic [DATA_W/8-1:0] wr_strb_i,
    input wire logic [DATA_W-1:0] wr_data_i
);
    logic [DATA_W-1:0] regs_q [DEPTH];

    assign rd_a_data_o = regs_q[rd_a_idx_i];
    assign rd_b_data_o = regs_q[rd_b_idx_i];

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                regs_q[i] <= '0;
            end
        end else if (ce_i && we_i) begin
            for (int i = 0; i < DATA_W / 8; i++) begin
                if (wr_strb_i[i]) begin
                    regs_q[wr_idx_i][i*8 +: 8] <= wr_data_i[i*8 +: 8];
                end
            end
        end
    end
endmodule : work_reg_file
`default_nettype wire

// [hdl/inc_unit.sv]
// Add one or two at byte or word width and derive the status flags
`timescale 1ns/10ps
`default_nettype none
module inc_unit
    import jump_inc_pkg::*;
(
    input wire logic [15:0] operand_i,
    input wire logic byte_i,
    input wire logic by_two_i,
    output logic [15:0] result_o,
    output logic [4:0] flags_o
);
    logic [16:0] amt;
    logic [16:0] sum_w;
    logic [8:0] sum_b;
    logic [4:0] sum_n;

    assign amt = by_two_i ? 17'h0_0002 : 17'h0_0001;
    assign sum_w = {1'h0, operand_i} + amt;
    assign sum_b = {1'h0, operand_i[7:0]} + amt[8:0];
    assign sum_n = {1'h0, operand_i[3:0]} + amt[4:0];

    always_comb begin
        flags_o = STATUS_RESET;
        flags_o[FLG_DIGIT_CARRY] = sum_n[4];
        if (byte_i) begin
            result_o = {operand_i[15:8], sum_b[7:0]};
            flags_o[FLG_C] = sum_b[8];
            flags_o[FLG_N] = sum_b[7];
            flags_o[FLG_OVERFLOW] = ~operand_i[7] & sum_b[7];
            flags_o[FLG_Z] = (sum_b[7:0] == 8'h00);
        end else begin
            result_o = sum_w[15:0];
            flags_o[FLG_C] = sum_w[16];
            flags_o[FLG_N] = sum_w[15];
            flags_o[FLG_OVERFLOW] = ~operand_i[15] & sum_w[15];
            flags_o[FLG_Z] = (sum_w[15:0] == 16'h0000);
        end
    end
endmodule : inc_unit
`default_nettype wire

// [hdl/jump_inc_exec.sv]
// Decode and execute of the jumps and the increment-by-one/two instructions
//
// Overview of operation
// - Absolute jump reaches whole program space, two words
// - Counter takes 23-bit literal, bit zero cleared
// - Target assembled from fields of both words
// - Indirect jump reaches lowest 32K words only
// - Indirect: upper counter bits zero, middle from register
// - Indirect: register bit zero ignored, counter even
// - Register increment-by-one: source plus one to destination
// - Register increment-by-two: source plus two to destination
// - Direct and indirect modes with pre/post modify
// - Size bit: zero word, one byte
// - Every increment updates five status flags
// - Recognise register increment-by-two upper pattern
// - Recognise file increment-by-two upper pattern
// - Separate mode and register fields per operand
// - Destination bit picks working or file register
// - Default working register is register zero
// - File address field selects memory operand
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module jump_inc_exec
    import jump_inc_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic CE_I,
    input wire logic [23:0] INSTR_I,
    input wire logic INSTR_VALID_I,
    output logic BUSY_O,
    output logic [22:0] PC_O,
    output logic PC_LOAD_O,
    output logic FLUSH_O,
    output logic [15:0] DMEM_ADDR_O,
    output logic DMEM_RE_O,
    input wire logic [15:0] DMEM_RDATA_I,
    output logic DMEM_WE_O,
    output logic [1:0] DMEM_WSTRB_O,
    output logic [15:0] DMEM_WDATA_O,
    output logic [4:0] STATUS_O
);
    function automatic logic [15:0] eff_addr(input logic [2:0] mode, input logic [15:0] r,
                                             input logic [15:0] step);
        if (mode == MODE_PRE_DEC) eff_addr = r - step;
        else if (mode == MODE_PRE_INC) eff_addr = r + step;
        else eff_addr = r;
    endfunction : eff_addr

    function automatic logic [15:0] ptr_next(input logic [2:0] mode, input logic [15:0] r,
                                             input logic [15:0] step);
        if (mode == MODE_POST_DEC || mode == MODE_PRE_DEC) ptr_next = r - step;
        else if (mode == MODE_POST_INC || mode == MODE_PRE_INC) ptr_next = r + step;
        else ptr_next = r;
    endfunction : ptr_next

    function automatic logic ptr_mod(input logic [2:0] mode);
        ptr_mod = (mode >= MODE_POST_DEC) && (mode <= MODE_PRE_INC);
    endfunction : ptr_mod

    function automatic logic [15:0] align(input logic [15:0] a, input logic is_byte);
        align = is_byte ? a : {a[15:1], 1'h0};
    endfunction : align

    state_t state_q, state_d;
    logic [23:0] instr_q;
    logic [15:0] operand_q;
    logic mem_src_q;
    logic [22:0] pc_q;
    logic load_q, flush_q, busy_q;
    logic [15:0] addr_q, wdata_q;
    logic re_q, we_q;
    logic [1:0] wstrb_q;
    logic [4:0] status_q;

    logic [15:0] rd_a_data, rd_b_data;
    logic rf_we;
    logic [3:0] rf_idx;
    logic [1:0] rf_strb;
    logic [15:0] rf_data;
    logic [15:0] alu_opnd, alu_res;
    logic [4:0] alu_flags;

    // Decode of the presented word
    logic take, is_jabs, is_jind, is_incf, is_incr, byte_i;
    logic [2:0] src_mode;
    logic [15:0] step_i;
    logic [22:0] abs_target, ind_target;

    assign take = (state_q == ST_IDLE) && INSTR_VALID_I;
    assign is_jabs = (INSTR_I[23:16] == OPC_JUMP_ABS);
    assign is_jind = (INSTR_I[23:4] == OPC_JUMP_IND);
    assign is_incf = (INSTR_I[23:16] == OPC_INC_FILE);
    assign is_incr = (INSTR_I[23:16] == OPC_INC_REG);
    assign byte_i = INSTR_I[BIT_BYTE];
    assign src_mode = INSTR_I[6:4];
    assign step_i = byte_i ? STEP_BYTE : STEP_WORD;
    assign abs_target = {INSTR_I[6:0], instr_q[15:1], 1'h0};
    assign ind_target = {7'h00, rd_a_data[15:1], 1'h0};

    // Decode of the executing increment
    logic x_file, x_byte, x_two, x_dsel;
    logic [2:0] dst_mode;
    logic [15:0] step_x, dst_addr, byte_wdata;

    assign x_file = (instr_q[23:16] == OPC_INC_FILE);
    assign x_byte = instr_q[BIT_BYTE];
    assign x_two = instr_q[BIT_BY_TWO];
    assign x_dsel = instr_q[BIT_DEST_SEL];
    assign dst_mode = instr_q[13:11];
    assign step_x = x_byte ? STEP_BYTE : STEP_WORD;
    assign dst_addr = align(eff_addr(dst_mode, rd_b_data, step_x), x_byte);
    assign byte_wdata = x_byte ? {alu_res[7:0], alu_res[7:0]} : alu_res;

    work_reg_file #(.DATA_W(16), .DEPTH(16)) u_regs (
        .clk_i(CLK_I),
        .reset_i(RESET_I),
        .ce_i(CE_I),
        .rd_a_idx_i(INSTR_I[3:0]),
        .rd_a_data_o(rd_a_data),
        .rd_b_idx_i(instr_q[10:7]),
        .rd_b_data_o(rd_b_data),
        .we_i(rf_we),
        .wr_idx_i(rf_idx),
        .wr_strb_i(rf_strb),
        .wr_data_i(rf_data)
    );

    // Byte lane of a memory operand follows the address bit zero
    always_comb begin
        if (!mem_src_q) alu_opnd = operand_q;
        else if (!x_byte) alu_opnd = DMEM_RDATA_I;
        else if (addr_q[0]) alu_opnd = {8'h00, DMEM_RDATA_I[15:8]};
        else alu_opnd = {8'h00, DMEM_RDATA_I[7:0]};
    end

    inc_unit u_inc (
        .operand_i(alu_opnd),
        .byte_i(x_byte),
        .by_two_i(x_two),
        .result_o(alu_res),
        .flags_o(alu_flags)
    );

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (INSTR_VALID_I) begin
                    if (is_jabs) state_d = ST_WORD2;
                    else if (is_jind) state_d = ST_FLUSH;
                    else if (is_incf) state_d = ST_RDWAIT;
                    else if (is_incr && src_mode == MODE_DIRECT) state_d = ST_EXEC;
                    else if (is_incr) state_d = ST_RDWAIT;
                end
            end
            ST_WORD2: begin
                if (INSTR_VALID_I) state_d = ST_FLUSH;
            end
            ST_FLUSH: state_d = ST_IDLE;
            ST_RDWAIT: state_d = ST_EXEC;
            ST_EXEC: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            state_q <= ST_IDLE;
            busy_q <= 1'h0;
        end else if (CE_I) begin
            state_q <= state_d;
            busy_q <= (state_d == ST_RDWAIT) || (state_d == ST_EXEC);
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            instr_q <= 24'h00_0000;
            operand_q <= 16'h0000;
            mem_src_q <= 1'h0;
        end else if (CE_I && take) begin
            instr_q <= INSTR_I;
            operand_q <= rd_a_data;
            mem_src_q <= is_incf || src_mode != MODE_DIRECT;
        end
    end

    // Program counter load and slot discard
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            pc_q <= PC_RESET;
            load_q <= 1'h0;
            flush_q <= 1'h0;
        end else if (CE_I) begin
            load_q <= 1'h0;
            flush_q <= 1'h0;
            if (state_q == ST_WORD2 && INSTR_VALID_I) begin
                pc_q <= abs_target;
                load_q <= 1'h1;
                flush_q <= 1'h1;
            end else if (take && is_jind) begin
                pc_q <= ind_target;
                load_q <= 1'h1;
                flush_q <= 1'h1;
            end
        end
    end

    // Data memory strobes
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            addr_q <= 16'h0000;
            re_q <= 1'h0;
            we_q <= 1'h0;
            wstrb_q <= 2'h0;
            wdata_q <= 16'h0000;
        end else if (CE_I) begin
            re_q <= 1'h0;
            we_q <= 1'h0;
            if (take && is_incf) begin
                addr_q <= align({3'h0, INSTR_I[12:0]}, byte_i);
                re_q <= 1'h1;
            end else if (take && is_incr && src_mode != MODE_DIRECT) begin
                addr_q <= align(eff_addr(src_mode, rd_a_data, step_i), byte_i);
                re_q <= 1'h1;
            end else if (state_q == ST_EXEC) begin
                if ((x_file && x_dsel) || (!x_file && dst_mode != MODE_DIRECT)) begin
                    if (!x_file) addr_q <= dst_addr;
                    we_q <= 1'h1;
                    wdata_q <= byte_wdata;
                    if (!x_byte) wstrb_q <= 2'h3;
                    else if (x_file ? addr_q[0] : dst_addr[0]) wstrb_q <= 2'h2;
                    else wstrb_q <= 2'h1;
                end
            end
        end
    end

    // Register file writes: source pointer at issue, result or pointer at execute
    always_comb begin
        rf_we = 1'h0;
        rf_idx = instr_q[10:7];
        rf_strb = 2'h3;
        rf_data = byte_wdata;
        if (take && is_incr && ptr_mod(src_mode)) begin
            rf_we = 1'h1;
            rf_idx = INSTR_I[3:0];
            rf_data = ptr_next(src_mode, rd_a_data, step_i);
        end else if (state_q == ST_EXEC) begin
            if (x_file && !x_dsel) begin
                rf_we = 1'h1;
                rf_idx = DEFAULT_WORK_REG_IDX;
                rf_strb = x_byte ? 2'h1 : 2'h3;
            end else if (!x_file && dst_mode == MODE_DIRECT) begin
                rf_we = 1'h1;
                rf_strb = x_byte ? 2'h1 : 2'h3;
            end else if (!x_file && ptr_mod(dst_mode)) begin
                rf_we = 1'h1;
                rf_data = ptr_next(dst_mode, rd_b_data, step_x);
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) status_q <= STATUS_RESET;
        else if (CE_I && state_q == ST_EXEC) status_q <= alu_flags;
    end

    assign BUSY_O = busy_q;
    assign PC_O = pc_q;
    assign PC_LOAD_O = load_q;
    assign FLUSH_O = flush_q;
    assign DMEM_ADDR_O = addr_q;
    assign DMEM_RE_O = re_q;
    assign DMEM_WE_O = we_q;
    assign DMEM_WSTRB_O = wstrb_q;
    assign DMEM_WDATA_O = wdata_q;
    assign STATUS_O = status_q;

    // Checks
    logic exec_ce;
    logic [7:0] amt8;
    assign exec_ce = CE_I && state_q == ST_EXEC;
    assign amt8 = x_two ? 8'h02 : 8'h01;

    property p_abs_target;
        @(posedge CLK_I) disable iff (RESET_I)
        CE_I && state_q == ST_WORD2 && INSTR_VALID_I |=> PC_LOAD_O && PC_O == $past(abs_target);
    endproperty
    a_abs_target: assert property (p_abs_target) else $error("bad absolute target");

    property p_pc_even;
        @(posedge CLK_I) disable iff (RESET_I) $changed(PC_O) |-> PC_LOAD_O && PC_O[0] == 1'h0;
    endproperty
    a_pc_even: assert property (p_pc_even) else $error("odd or unannounced counter");

    property p_ind_target;
        @(posedge CLK_I) disable iff (RESET_I)
        CE_I && take && is_jind |=> PC_O[22:16] == 7'h00 && PC_O == $past(ind_target);
    endproperty
    a_ind_target: assert property (p_ind_target) else $error("bad indirect target");

    property p_flush_slot;
        @(posedge CLK_I) disable iff (RESET_I)
        PC_LOAD_O |-> FLUSH_O && state_q == ST_FLUSH ##1 (!$past(CE_I) || !FLUSH_O);
    endproperty
    a_flush_slot: assert property (p_flush_slot) else $error("slot not discarded");

    property p_inc_sum;
        @(posedge CLK_I) disable iff (RESET_I)
        exec_ce |-> (x_byte ? alu_res[7:0] == alu_opnd[7:0] + amt8
                            : alu_res == alu_opnd + {8'h00, amt8});
    endproperty
    a_inc_sum: assert property (p_inc_sum) else $error("wrong increment");

    property p_strobe_width;
        @(posedge CLK_I) disable iff (RESET_I)
        exec_ce && x_file && x_dsel |=> DMEM_WE_O && (x_byte ? $onehot(DMEM_WSTRB_O)
                                                              : DMEM_WSTRB_O == 2'h3);
    endproperty
    a_strobe_width: assert property (p_strobe_width) else $error("bad width");

    property p_w0_dest;
        @(posedge CLK_I) disable iff (RESET_I)
        exec_ce && x_file && !x_dsel |-> rf_we && rf_idx == DEFAULT_WORK_REG_IDX && !we_q;
    endproperty
    a_w0_dest: assert property (p_w0_dest) else $error("file result not to reg 0");

    property p_zero_flag;
        @(posedge CLK_I) disable iff (RESET_I)
        exec_ce |=> STATUS_O[FLG_Z] == $past(alu_flags[FLG_Z]) && STATUS_O == $past(alu_flags);
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("flags not updated");

    property p_read_to_exec;
        @(posedge CLK_I) disable iff (RESET_I)
        DMEM_RE_O && CE_I |-> state_q == ST_RDWAIT ##1 state_q == ST_EXEC;
    endproperty
    a_read_to_exec: assert property (p_read_to_exec) else $error("read not executed");

    c_abs_jump: cover property (@(posedge CLK_I) disable iff (RESET_I)
        state_q == ST_WORD2 ##1 PC_LOAD_O);
    c_ind_jump: cover property (@(posedge CLK_I) disable iff (RESET_I) take && is_jind);
    c_mem_dest: cover property (@(posedge CLK_I) disable iff (RESET_I)
        exec_ce && !x_file && dst_mode == MODE_PRE_INC);
    c_file_w0: cover property (@(posedge CLK_I) disable iff (RESET_I)
        exec_ce && x_file && !x_dsel && x_two);
endmodule : jump_inc_exec
`default_nettype wire

// [test/dmem_model.sv]
// Behavioural data memory on the far side of the increment execute path
`timescale 1ns/10ps
`default_nettype none
module dmem_model (
    input wire logic clk_i,
    input wire logic re_i,
    input wire logic [15:0] addr_i,
    output logic [15:0] rdata_o,
    input wire logic we_i,
    input wire logic [1:0] wstrb_i,
    input wire logic [15:0] wdata_i
);
    logic [15:0] mem [0:32767];

    initial begin
        rdata_o = 16'h0000;
    end

    // Read data are good only in the cycle after the strobe; otherwise they toggle
    always @(posedge clk_i) begin
        if (re_i) begin
            rdata_o <= mem[addr_i[15:1]];
        end else begin
            rdata_o <= ~rdata_o;
        end
        if (we_i && wstrb_i[0]) begin
            mem[addr_i[15:1]][7:0] <= wdata_i[7:0];
        end
        if (we_i && wstrb_i[1]) begin
            mem[addr_i[15:1]][15:8] <= wdata_i[15:8];
        end
    end
endmodule : dmem_model
`default_nettype wire

// [test/jump_and_increment_exec_test.sv]
// Self-checking bench for the jump and increment execute block
`timescale 1ns/10ps
`default_nettype none
module jump_and_increment_exec_test;
    import jump_inc_pkg::*;

    logic CLK_I = 1'b0;
    logic RESET_I = 1'b1;
    logic CE_I = 1'b1;
    logic [23:0] INSTR_I = 24'h00_0000;
    logic INSTR_VALID_I = 1'b0;
    logic BUSY_O;
    logic [22:0] PC_O;
    logic PC_LOAD_O;
    logic FLUSH_O;
    logic [15:0] DMEM_ADDR_O;
    logic DMEM_RE_O;
    logic [15:0] DMEM_RDATA_I;
    logic DMEM_WE_O;
    logic [1:0] DMEM_WSTRB_O;
    logic [15:0] DMEM_WDATA_O;
    logic [4:0] STATUS_O;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    int pl_at;
    int re_at;
    int we_at;
    int busy_n;
    logic [15:0] w_addr;
    logic [1:0] w_strb;
    logic [15:0] w_data;

    jump_inc_exec uut (
        .CLK_I(CLK_I), .RESET_I(RESET_I), .CE_I(CE_I), .INSTR_I(INSTR_I),
        .INSTR_VALID_I(INSTR_VALID_I), .BUSY_O(BUSY_O), .PC_O(PC_O), .PC_LOAD_O(PC_LOAD_O),
        .FLUSH_O(FLUSH_O), .DMEM_ADDR_O(DMEM_ADDR_O), .DMEM_RE_O(DMEM_RE_O),
        .DMEM_RDATA_I(DMEM_RDATA_I), .DMEM_WE_O(DMEM_WE_O), .DMEM_WSTRB_O(DMEM_WSTRB_O),
        .DMEM_WDATA_O(DMEM_WDATA_O), .STATUS_O(STATUS_O)
    );

    dmem_model dmem (
        .clk_i(CLK_I), .re_i(DMEM_RE_O), .addr_i(DMEM_ADDR_O), .rdata_o(DMEM_RDATA_I),
        .we_i(DMEM_WE_O), .wstrb_i(DMEM_WSTRB_O), .wdata_i(DMEM_WDATA_O)
    );

    always #25 CLK_I = ~CLK_I;

    task automatic print_verdict;
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict

    // Hang guard: the whole sequence needs well under a hundred cycles
    always @(posedge CLK_I) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            print_verdict();
        end
    end

    task automatic cmp(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : cmp

    // Present one instruction word for one cycle; called just after a rising edge
    task automatic issue(input logic [23:0] w);
        INSTR_I <= w;
        INSTR_VALID_I <= 1'b1;
        @(posedge CLK_I);
    endtask : issue

    // Drop valid and record strobes seen in the next n cycles
    task automatic watch(input int n);
        INSTR_VALID_I <= 1'b0;
        pl_at = 0;
        re_at = 0;
        we_at = 0;
        busy_n = 0;
        for (int i = 1; i <= n; i++) begin
            #1;
            if (PC_LOAD_O === 1'b1 && FLUSH_O === 1'b1) begin
                pl_at = i;
            end
            if (DMEM_RE_O === 1'b1) begin
                re_at = i;
            end
            if (BUSY_O === 1'b1) begin
                busy_n++;
            end
            if (DMEM_WE_O === 1'b1) begin
                we_at = i;
                w_addr = DMEM_ADDR_O;
                w_strb = DMEM_WSTRB_O;
                w_data = DMEM_WDATA_O;
            end
            @(posedge CLK_I);
        end
    endtask : watch

    task automatic t_file;
        issue(24'hEC_9000);
        watch(4);
        cmp("file read cycle", 24'd1, re_at[23:0]);
        cmp("file busy cycles", 24'd2, busy_n[23:0]);
        cmp("file write to memory", 24'd0, we_at[23:0]);
        cmp("status after word add two", 24'h00_0018, {19'h0, STATUS_O});
        // Byte form requested through the size bit, result back to memory
        issue(24'hEC_7000);
        watch(5);
        cmp("byte write address", 24'h00_1000, {8'h00, w_addr});
        cmp("byte write lanes", 24'h00_0001, {22'h0, w_strb});
        cmp("byte write data", 24'h00_8080, {8'h00, w_data});
        cmp("status after byte add one", 24'h00_001C, {19'h0, STATUS_O});
        cmp("memory word", 24'h00_8F80, {8'h00, dmem.mem[16'h0800]});
        $display("test file forms done");
    endtask : t_file

    task automatic t_reg;
        issue(24'hE8_8080);
        watch(3);
        cmp("direct form memory use", 24'd0, re_at[23:0] + we_at[23:0]);
        cmp("direct form busy cycles", 24'd1, busy_n[23:0]);
        cmp("status after direct add two", 24'h00_0008, {19'h0, STATUS_O});
        issue(24'hE8_0801);
        watch(4);
        cmp("indirect dest address", 24'h00_8F80, {8'h00, w_addr});
        cmp("word write lanes", 24'h00_0003, {22'h0, w_strb});
        cmp("add one result", 24'h00_8F84, {8'h00, w_data});
        issue(24'hE8_C830);
        watch(5);
        cmp("post modify read", 24'd1, re_at[23:0]);
        cmp("post modified dest", 24'h00_8F82, {8'h00, w_addr});
        cmp("byte lane", 24'h00_0001, {22'h0, w_strb});
        cmp("byte add two data", 24'h00_9191, {8'h00, w_data});
        cmp("status after byte add two", 24'h00_0018, {19'h0, STATUS_O});
        // Word add two, source pre-decrement, destination pre-increment
        issue(24'hE8_A8C0);
        watch(5);
        cmp("pre modified dest", 24'h00_8F84, {8'h00, w_addr});
        cmp("pre modify add two data", 24'h00_8F86, {8'h00, w_data});
        cmp("status after pre modify", 24'h00_0008, {19'h0, STATUS_O});
        // Byte add one, source post-decrement, odd destination byte
        issue(24'hE8_4820);
        watch(5);
        cmp("odd byte dest", 24'h00_8F7F, {8'h00, w_addr});
        cmp("odd byte lane", 24'h00_0002, {22'h0, w_strb});
        cmp("byte add one data", 24'h00_8585, {8'h00, w_data});
        cmp("status after odd byte", 24'h00_0008, {19'h0, STATUS_O});
        $display("test register forms done");
    endtask : t_reg

    task automatic t_ind;
        issue(24'h01_4001);
        watch(3);
        cmp("indirect load cycle", 24'd1, pl_at[23:0]);
        cmp("indirect target", 24'h00_8F84, {1'b0, PC_O});
        // Word offered while the clock enable is low must not be taken
        CE_I <= 1'b0;
        issue(24'h01_4000);
        CE_I <= 1'b1;
        watch(3);
        cmp("frozen jump load", 24'd0, pl_at[23:0]);
        cmp("frozen target", 24'h00_8F84, {1'b0, PC_O});
        $display("test indirect jump done");
    endtask : t_ind

    task automatic t_abs;
        issue(24'h04_8765);
        issue(24'h00_007F);
        // Word in the flush slot must not run
        INSTR_I <= 24'hEC_9000;
        INSTR_VALID_I <= 1'b1;
        #1;
        cmp("jump load pulse", 24'd1, {23'h0, PC_LOAD_O});
        cmp("jump flush pulse", 24'd1, {23'h0, FLUSH_O});
        cmp("absolute target", 24'h7F_8764, {1'b0, PC_O});
        @(posedge CLK_I);
        watch(4);
        cmp("discarded word access", 24'd0, re_at[23:0] + pl_at[23:0]);
        $display("test absolute jump done");
    endtask : t_abs

    initial begin
        dmem.mem[16'h0800] = 16'h8F7F;
        repeat (4) @(posedge CLK_I);
        RESET_I <= 1'b0;
        cmp("reset program counter", 24'h00_0000, {1'b0, PC_O});
        cmp("reset status", 24'h00_0000, {19'h0, STATUS_O});
        t_file();
        t_reg();
        t_ind();
        t_abs();
        print_verdict();
    end
endmodule : jump_and_increment_exec_test
`default_nettype wire
